// >>> dpsfh_host.sv
`timescale 1ns/1ps

module dpsfh_host
   import dpsfh_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic cmdValid,
   input wire logic cmdTake,
   input wire logic [INDEX_W-1:0] cmdIndex,
   input wire logic pollEn,
   input wire logic abort,
   output logic cmdReady,
   output logic respValid,
   output logic respGranted,
   output logic [TOKEN_COUNT-1:0] ownedMask,
   output logic chipSelN,
   output logic tokenSelN,
   output logic writeN,
   output logic outEnN,
   output logic [INDEX_W-1:0] tokenIndex,
   output logic [DATA_W-1:0] dataOut,
   output logic dataOe,
   input wire logic [DATA_W-1:0] dataIn
);

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   function automatic logic [TOKEN_COUNT-1:0] tokenBit(input logic [INDEX_W-1:0] idx);
      tokenBit = TOKEN_COUNT'(1) << idx;
   endfunction : tokenBit

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   dpsfh_state_e state_q, state_d;
   dpsfh_op_e op_q, op_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [INIT_W-1:0] initCnt_q, initCnt_d;
   logic [INDEX_W-1:0] idx_q, idx_d;
   logic wrVal_q, wrVal_d;
   logic readBit_q, readBit_d;
   logic [TOKEN_COUNT-1:0] owned_q, owned_d;
   logic respValid_q, respValid_d;
   logic respGranted_q, respGranted_d;
   logic ready_q;
   logic selN_q, writeN_q, oeN_q, dataOe_q, chipSelN_q;
   logic [DATA_W-1:0] dataOut_q;
   logic [DATA_W-1:0] dataMeta_q, dataSync_q;
   wire cntDone = (cnt_q == CNT_ZERO);
   wire accessD = (state_d == ST_WRITE) || (state_d == ST_READ);
   wire retryPoll = pollEn && !abort;

   // Two-stage capture of the data pins
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dataMeta_q <= '0;
         dataSync_q <= '0;
      end else begin
         dataMeta_q <= dataIn;
         dataSync_q <= dataMeta_q;
      end
   end

   // Sequencer: one pin access, then a deselected gap
   always_comb begin
      state_d = state_q;
      op_d = op_q;
      cnt_d = cntDone ? cnt_q : cnt_q - 4'h1;
      initCnt_d = initCnt_q;
      idx_d = idx_q;
      wrVal_d = wrVal_q;
      readBit_d = readBit_q;
      owned_d = owned_q;
      respValid_d = 1'b0;
      respGranted_d = respGranted_q;
      case (state_q)
         ST_IDLE: begin
            if (cmdValid) begin
               idx_d = cmdIndex;
               state_d = ST_WRITE;
               cnt_d = WRITE_LOAD;
               if (cmdTake) begin
                  op_d = OP_TAKE_WR;
                  wrVal_d = FLAG_TAKE;
               end else begin
                  op_d = OP_RELEASE;
                  wrVal_d = FLAG_FREE;
               end
            end
         end
         ST_WRITE: begin
            if (cntDone) begin
               state_d = ST_GAP;
               cnt_d = GAP_LOAD;
            end
         end
         ST_READ: begin
            if (cntDone) begin
               readBit_d = dataSync_q[0]; // Flag is replicated, one bit suffices
               state_d = ST_GAP;
               cnt_d = GAP_LOAD;
            end
         end
         ST_GAP: begin
            if (cntDone) begin
               case (op_q)
                  OP_INIT: begin
                     if (initCnt_q == INIT_DONE) begin
                        state_d = ST_IDLE;
                     end else begin
                        idx_d = initCnt_q[INDEX_W-1:0];
                        wrVal_d = FLAG_FREE;
                        initCnt_d = initCnt_q + INIT_STEP;
                        state_d = ST_WRITE;
                        cnt_d = WRITE_LOAD;
                     end
                  end
                  OP_TAKE_WR: begin
                     op_d = OP_TAKE_RD;
                     state_d = ST_READ;
                     cnt_d = READ_LOAD;
                  end
                  OP_TAKE_RD: begin
                     if (readBit_q == FLAG_TAKE) begin
                        owned_d = owned_q | tokenBit(idx_q);
                        respValid_d = 1'b1;
                        respGranted_d = 1'b1;
                        state_d = ST_IDLE;
                     end else if (retryPoll) begin
                        state_d = ST_READ;
                        cnt_d = READ_LOAD;
                     end else begin
                        op_d = OP_WITHDRAW;
                        wrVal_d = FLAG_FREE;
                        state_d = ST_WRITE;
                        cnt_d = WRITE_LOAD;
                     end
                  end
                  OP_WITHDRAW: begin
                     respValid_d = 1'b1;
                     respGranted_d = 1'b0;
                     state_d = ST_IDLE;
                  end
                  OP_RELEASE: begin
                     owned_d = owned_q & ~tokenBit(idx_q);
                     respValid_d = 1'b1;
                     respGranted_d = 1'b0;
                     state_d = ST_IDLE;
                  end
                  default: begin
                     state_d = ST_IDLE;
                  end
               endcase
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Registered control state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_GAP;
         op_q <= OP_INIT;
         cnt_q <= CNT_ZERO;
         initCnt_q <= '0;
         idx_q <= '0;
         wrVal_q <= FLAG_FREE;
         readBit_q <= FLAG_FREE;
         owned_q <= '0;
         respValid_q <= 1'b0;
         respGranted_q <= 1'b0;
         ready_q <= 1'b0;
      end else begin
         state_q <= state_d;
         op_q <= op_d;
         cnt_q <= cnt_d;
         initCnt_q <= initCnt_d;
         idx_q <= idx_d;
         wrVal_q <= wrVal_d;
         readBit_q <= readBit_d;
         owned_q <= owned_d;
         respValid_q <= respValid_d;
         respGranted_q <= respGranted_d;
         ready_q <= (state_d == ST_IDLE);
      end
   end

   // Registered pin drive, taken from the next state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         selN_q <= PIN_IDLE;
         writeN_q <= PIN_IDLE;
         oeN_q <= PIN_IDLE;
         dataOe_q <= 1'b0;
         dataOut_q <= '0;
         chipSelN_q <= PIN_IDLE;
      end else begin
         chipSelN_q <= PIN_IDLE; // RAM array never selected here
         selN_q <= !accessD;
         writeN_q <= !(state_d == ST_WRITE);
         oeN_q <= !(state_d == ST_READ);
         dataOe_q <= (state_d == ST_WRITE);
         dataOut_q <= {DATA_W{wrVal_d}}; // Bit 0 carries the request
      end
   end

   // Outputs
   assign cmdReady = ready_q;
   assign respValid = respValid_q;
   assign respGranted = respGranted_q;
   assign ownedMask = owned_q;
   assign chipSelN = chipSelN_q;
   assign tokenSelN = selN_q;
   assign writeN = writeN_q;
   assign outEnN = oeN_q;
   assign tokenIndex = idx_q;
   assign dataOut = dataOut_q;
   assign dataOe = dataOe_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [INIT_W-1:0] onesWritten_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         onesWritten_q <= '0;
      end else if (op_q == OP_INIT && state_q == ST_WRITE && cntDone && dataOut_q[0]) begin
         onesWritten_q <= onesWritten_q + INIT_STEP;
      end
   end

   read_gap_a: assert property (@(posedge clk) disable iff (!arst_n)
      (state_q == ST_READ && cntDone) |=> tokenSelN && outEnN)
      else $error("read not followed by deselect");

   take_order_a: assert property (@(posedge clk) disable iff (!arst_n)
      (state_q == ST_WRITE && op_q == OP_TAKE_WR && cntDone && !dataOut_q[0])
      |=> ##[1:8] (!tokenSelN && !outEnN && writeN))
      else $error("take write not followed by read");

   fail_withdraw_a: assert property (@(posedge clk) disable iff (!arst_n)
      (respValid && !respGranted && $past(op_q, 2) == OP_WITHDRAW)
      |-> dataOut_q[0] == FLAG_FREE)
      else $error("failed take left request pending");

   release_one_a: assert property (@(posedge clk) disable iff (!arst_n)
      (!tokenSelN && !writeN && op_q == OP_RELEASE) |-> dataOut[0] && dataOe)
      else $error("release did not write one");

   init_all_a: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(cmdReady) |-> onesWritten_q == INIT_DONE)
      else $error("ready before all tokens freed");

   index_stable_a: assert property (@(posedge clk) disable iff (!arst_n)
      (!tokenSelN && $past(!tokenSelN)) |-> $stable(tokenIndex))
      else $error("index moved during access");

   grant_cover_c: cover property (@(posedge clk) disable iff (!arst_n)
      respValid && respGranted);
   poll_cover_c: cover property (@(posedge clk) disable iff (!arst_n)
      (state_q == ST_GAP && op_q == OP_TAKE_RD && readBit_q && retryPoll && cntDone));
   withdraw_cover_c: cover property (@(posedge clk) disable iff (!arst_n)
      respValid && !respGranted && ownedMask == '0);

endmodule : dpsfh_host

// >>> dpsfh_pkg.sv
package dpsfh_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int DATA_W = 16;
   localparam int INDEX_W = 3;
   localparam int TOKEN_COUNT = 8;
   localparam int CNT_W = 4;
   localparam int INIT_W = 4;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int WRITE_PULSE_NS = 50; // Least write strobe width
   localparam int READ_ACCESS_NS = 50; // Least select-to-data time
   localparam int GAP_NS = 25; // Least deselect time between accesses
   localparam int SYNC_STAGES = 2;
   localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                             + SYNC_STAGES;
   localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [CNT_W-1:0] WRITE_LOAD = CNT_W'(WRITE_CYC - 1);
   localparam logic [CNT_W-1:0] READ_LOAD = CNT_W'(READ_CYC - 1);
   localparam logic [CNT_W-1:0] GAP_LOAD = CNT_W'(GAP_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [INIT_W-1:0] INIT_DONE = INIT_W'(TOKEN_COUNT);
   localparam logic [INIT_W-1:0] INIT_STEP = 4'h1;

   // ----------------------------------------------------------------
   // Pin levels and reset values
   // ----------------------------------------------------------------
   localparam logic PIN_IDLE = 1'h1; // Strobes are active low
   localparam logic FLAG_TAKE = 1'h0; // Zero requests a token
   localparam logic FLAG_FREE = 1'h1; // One releases or withdraws

   // ----------------------------------------------------------------
   // Machine states and operations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WRITE = 2'b01,
      ST_READ = 2'b10,
      ST_GAP = 2'b11
   } dpsfh_state_e;

   typedef enum logic [2:0] {
      OP_INIT = 3'b000,
      OP_TAKE_WR = 3'b001,
      OP_TAKE_RD = 3'b010,
      OP_WITHDRAW = 3'b011,
      OP_RELEASE = 3'b100
   } dpsfh_op_e;

endpackage : dpsfh_pkg

// >>> dpsfh_sem_model.sv
`timescale 1ns/1ps

module dpsfh_sem_model
   import dpsfh_pkg::*;
(
   input wire logic clk,
   input wire logic lSelN,
   input wire logic lWrN,
   input wire logic lOeN,
   input wire logic [INDEX_W-1:0] lIdx,
   input wire logic [DATA_W-1:0] lDin,
   output logic [DATA_W-1:0] lDout,
   input wire logic rSelN,
   input wire logic rWrN,
   input wire logic rOeN,
   input wire logic [INDEX_W-1:0] rIdx,
   input wire logic [DATA_W-1:0] rDin,
   output logic [DATA_W-1:0] rDout
);
   // Power-up contents are arbitrary, nothing clears them
   logic [TOKEN_COUNT-1:0] reqL = 8'h00;
   logic [TOKEN_COUNT-1:0] reqR = 8'h3c;
   logic [TOKEN_COUNT-1:0] ownL = 8'h00;
   logic [TOKEN_COUNT-1:0] ownR = 8'h00;
   logic latL = 1'h0;
   logic latR = 1'h0;
   logic rdL = 1'h0;
   logic rdR = 1'h0;

   // ----------------------------------------------------------------
   // Token logic, evaluated mid-cycle
   // ----------------------------------------------------------------
   always @(negedge clk) begin
      if (!lSelN && !lWrN) reqL[lIdx] = lDin[0];
      if (!rSelN && !rWrN) reqR[rIdx] = rDin[0];
      for (int i = 0; i < TOKEN_COUNT; i++) begin
         if (ownL[i] && reqL[i]) ownL[i] = 1'b0;
         if (ownR[i] && reqR[i]) ownR[i] = 1'b0;
         if (!ownL[i] && !ownR[i] && !reqL[i]) ownL[i] = 1'b1;
         else if (!ownL[i] && !ownR[i] && !reqR[i]) ownR[i] = 1'b1;
      end
      if (!lSelN && !lOeN && !rdL) latL = ~ownL[lIdx];
      if (!rSelN && !rOeN && !rdR) latR = ~ownR[rIdx];
      rdL = !lSelN && !lOeN;
      rdR = !rSelN && !rOeN;
   end

   // Flag spread on all bits; released pins show the inverse
   assign lDout = rdL ? {DATA_W{latL}} : {DATA_W{~latL}};
   assign rDout = rdR ? {DATA_W{latR}} : {DATA_W{~latR}};
endmodule : dpsfh_sem_model

// >>> dual_port_semaphore_flags_tb.sv
`timescale 1ns/1ps

module dual_port_semaphore_flags_tb
   import dpsfh_pkg::*;
;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic cmdValid = 1'b0;
   logic cmdTake = 1'b0;
   logic [INDEX_W-1:0] cmdIndex = 3'h0;
   logic pollEn = 1'b0;
   logic abort = 1'b0;
   logic cmdReady, respValid, respGranted, tokenSelN, writeN, outEnN, chipSelN, dataOe;
   logic [TOKEN_COUNT-1:0] ownedMask;
   logic [INDEX_W-1:0] tokenIndex;
   logic [DATA_W-1:0] dataOut, dataIn, rDout;
   logic rSelN = 1'b1;
   logic rWrN = 1'b1;
   logic rOeN = 1'b1;
   logic [INDEX_W-1:0] rIdx = 3'h0;
   logic [DATA_W-1:0] rDin = 16'h0000;
   int errors = 0;
   int compares = 0;
   logic [DATA_W-1:0] hostBus;

   // Released host bus shows the inverse of its last drive
   assign hostBus = dataOe ? dataOut : ~dataOut;

   dpsfh_host u_dpsfh_host (.clk(clk), .arst_n(arst_n), .cmdValid(cmdValid),
      .cmdTake(cmdTake), .cmdIndex(cmdIndex), .pollEn(pollEn), .abort(abort),
      .cmdReady(cmdReady), .respValid(respValid), .respGranted(respGranted),
      .ownedMask(ownedMask), .chipSelN(chipSelN), .tokenSelN(tokenSelN), .writeN(writeN),
      .outEnN(outEnN), .tokenIndex(tokenIndex), .dataOut(dataOut), .dataOe(dataOe),
      .dataIn(dataIn));
   dpsfh_sem_model u_dpsfh_sem_model (.clk(clk), .lSelN(tokenSelN), .lWrN(writeN),
      .lOeN(outEnN), .lIdx(tokenIndex), .lDin(hostBus), .lDout(dataIn), .rSelN(rSelN),
      .rWrN(rWrN), .rOeN(rOeN), .rIdx(rIdx), .rDin(rDin), .rDout(rDout));

   // Clock
   initial begin
      forever #12.5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic do_cmd(input logic take, input logic [INDEX_W-1:0] i, output logic g);
      int n;
      n = 0;
      @(posedge clk);
      cmdValid <= 1'b1;
      cmdTake <= take;
      cmdIndex <= i;
      do @(posedge clk); while (cmdReady !== 1'b1 && ++n < 200);
      cmdValid <= 1'b0;
      do @(posedge clk); while (respValid !== 1'b1 && ++n < 600);
      chk(16'(respValid), 16'h1, "response");
      g = respGranted;
   endtask : do_cmd

   // Far-side write, upper data bits opposite to bit 0
   task automatic r_write(input logic [INDEX_W-1:0] i, input logic b);
      @(posedge clk);
      rSelN <= 1'b0;
      rWrN <= 1'b0;
      rIdx <= i;
      rDin <= {~{15{b}}, b};
      repeat (2) @(posedge clk);
      rSelN <= 1'b1;
      rWrN <= 1'b1;
   endtask : r_write

   task automatic r_read(input logic [INDEX_W-1:0] i, input logic e, input string m);
      @(posedge clk);
      rSelN <= 1'b0;
      rOeN <= 1'b0;
      rIdx <= i;
      repeat (2) @(posedge clk);
      chk(rDout, {16{e}}, m);
      rSelN <= 1'b1;
      rOeN <= 1'b1;
   endtask : r_read

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_handover();
      logic g;
      do_cmd(1'b1, 3'h3, g);
      chk(16'(g), 16'h1, "take free");
      chk(16'(ownedMask), 16'h8, "mask");
      r_read(3'h3, 1'b1, "other view");
      r_write(3'h3, 1'b0);
      r_read(3'h3, 1'b1, "locked out");
      do_cmd(1'b1, 3'h3, g);
      chk(16'(g), 16'h1, "still owner");
      do_cmd(1'b0, 3'h3, g);
      chk(16'(ownedMask), 16'h0, "released");
      r_read(3'h3, 1'b0, "handover");
      do_cmd(1'b1, 3'h3, g);
      chk(16'(g), 16'h0, "new owner kept");
      r_write(3'h3, 1'b1);
   endtask : t_handover

   task automatic t_eight();
      logic g;
      r_write(3'h5, 1'b0);
      for (int i = 0; i < TOKEN_COUNT; i++) begin
         do_cmd(1'b1, 3'(i), g);
         chk(16'(g), 16'(i != 5), "token take");
      end
      chk(16'(ownedMask), 16'hdf, "all mask");
      for (int i = 0; i < TOKEN_COUNT; i++) do_cmd(1'b0, 3'(i), g);
      chk(16'(ownedMask), 16'h0, "all freed");
      r_write(3'h5, 1'b1);
   endtask : t_eight

   task automatic t_contend();
      logic g;
      r_write(3'h2, 1'b0);
      pollEn <= 1'b1;
      fork
         do_cmd(1'b1, 3'h2, g);
         begin repeat (40) @(posedge clk); r_write(3'h2, 1'b1); end
      join
      chk(16'(g), 16'h1, "poll wins");
      do_cmd(1'b0, 3'h2, g);
      r_write(3'h2, 1'b0);
      fork
         do_cmd(1'b1, 3'h2, g);
         begin repeat (40) @(posedge clk); abort <= 1'b1; end
      join
      chk(16'(g), 16'h0, "aborted");
      abort <= 1'b0;
      pollEn <= 1'b0;
      r_write(3'h2, 1'b1);
      r_write(3'h2, 1'b0);
      r_read(3'h2, 1'b0, "withdrawn");
      r_write(3'h2, 1'b1);
   endtask : t_contend

   // Far side early, level, late
   task automatic t_race();
      logic g;
      for (int d = 0; d < 3; d++) begin
         fork
            do_cmd(1'b1, 3'h6, g);
            begin repeat (d) @(posedge clk); r_write(3'h6, 1'b0); end
         join
         r_read(3'h6, g, "one owner");
         if (d != 1) chk(16'(g), 16'(d == 2), "early wins");
         do_cmd(1'b0, 3'h6, g);
         r_write(3'h6, 1'b1);
      end
   endtask : t_race

   // Wait for the host's own init, far side optionally freeing too
   task automatic t_init(input logic farToo);
      int n;
      n = 0;
      if (farToo) begin
         for (int i = 0; i < TOKEN_COUNT; i++) r_write(3'(i), 1'b1);
      end
      do @(posedge clk); while (cmdReady !== 1'b1 && ++n < 100);
      chk(16'(cmdReady), 16'h1, "init done");
      chk(16'(ownedMask), 16'h0, "after init");
      chk(16'(chipSelN), 16'h1, "array unselected");
      chk(16'(dataOe), 16'h0, "bus released");
   endtask : t_init

   // Mid-run reset while a token is held; host init must free it
   task automatic t_reset();
      logic g;
      do_cmd(1'b1, 3'h1, g);
      chk(16'(g), 16'h1, "held before reset");
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (5) @(posedge clk);
      chk(16'(ownedMask), 16'h0, "mask in reset");
      chk(16'(tokenSelN), 16'h1, "select in reset");
      chk(16'(cmdReady), 16'h0, "busy in reset");
      arst_n <= 1'b1;
      t_init(1'b0);
      r_write(3'h1, 1'b0);
      r_read(3'h1, 1'b0, "freed by init");
      r_write(3'h1, 1'b1);
   endtask : t_reset

   task automatic tally_and_finish();
      if (errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      t_init(1'b1);
      t_handover();
      t_eight();
      t_contend();
      t_race();
      t_reset();
      tally_and_finish();
   end

   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule : dual_port_semaphore_flags_tb
